//--- psr_register_file.sv
// Eight 64-bit packed-integer registers sharing storage with the FP data stack.
// Assumes the core sequences instructions; one request per cycle, results next edge.
`include "psr_map.svh"
`timescale 1ns/1ps

// What this block does
// - Eight 64-bit packed integer registers.
// - Storage shared with floating-point stack registers.
// - Lanes as bytes, words or doublewords.
// - Every lane computed independently, in parallel.
// - Full-width access for 64-bit transfers, ALU.
// - Half-width access for 32-bit transfers.
// - Never used as memory address sources.
// - Register format equals memory quadword format.
// - Moves are whole 64-bit blocks.
// - Memory stores little-endian, lowest lane first.
// - Usable in every mode, no new mode.
// - Compatibility, 64-bit modes behave as protected.
module psr_register_file
(
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire psr_pkg::psr_req_t      req,
  input  wire logic [1:0]             exec_mode,
  input  wire logic [`PSR_IDX_W-1:0]  rd_idx,
  input  wire logic                   fp_wr_en,
  input  wire logic [`PSR_IDX_W-1:0]  fp_wr_idx,
  input  wire psr_pkg::psr_fp_slot_t  fp_wr_slot,
  input  wire logic [`PSR_IDX_W-1:0]  fp_rd_idx,
  output logic [`PSR_DATA_W-1:0]      rd_data,
  output logic [`PSR_DATA_W-1:0]      mem_store_bytes,
  output logic [`PSR_HALF_W-1:0]      half_data,
  output psr_pkg::psr_fp_slot_t       fp_rd_slot,
  output logic                        wr_done
);

  ////////////////////////////////////////////////////////////////////////
  // Shared storage: packed view is the mantissa, FP view adds the exponent
  psr_pkg::psr_fp_slot_t slot_reg  [`PSR_NREGS]; // Physical registers
  psr_pkg::psr_fp_slot_t slot_next [`PSR_NREGS]; // Next contents
  logic [`PSR_DATA_W-1:0] rd_data_reg;            // Registered read port
  logic [`PSR_DATA_W-1:0] rd_data_next;           // Next read value
  logic [`PSR_DATA_W-1:0] store_reg;              // Registered memory image
  logic [`PSR_DATA_W-1:0] store_next;             // Next memory image
  logic [`PSR_HALF_W-1:0] half_reg;               // Registered low half
  logic [`PSR_HALF_W-1:0] half_next;              // Next low half
  psr_pkg::psr_fp_slot_t  fp_rd_reg;              // Registered FP view
  psr_pkg::psr_fp_slot_t  fp_rd_next;             // Next FP view
  logic                   done_reg;               // Write completed pulse
  logic                   done_next;              // Next pulse value
  logic [`PSR_DATA_W-1:0] opa;                    // First operand
  logic [`PSR_DATA_W-1:0] opb;                    // Second operand
  logic [`PSR_DATA_W-1:0] alu_res;                // Lane unit result
  logic [`PSR_DATA_W-1:0] unpk_res;               // Interleave result
  logic [`PSR_DATA_W-1:0] wr_val;                 // Value headed for dst

  ////////////////////////////////////////////////////////////////////////
  // Operand fetch; no address path exists, so contents never form addresses
  assign opa = slot_reg[req.src_a].mantissa;
  assign opb = (req.src == psr_pkg::PSR_SRC_MEM64) ? req.wdata : slot_reg[req.src_b].mantissa;

  psr_lane_alu u_alu
  (
    .opa    (opa),
    .opb    (opb),
    .op     (req.op),
    .lane   (req.lane),
    .result (alu_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // Unpack interleaves the low or high halves of both sources per lane;
  // the low form only reads 32 bits of each operand
  always_comb
  begin
    logic [`PSR_HALF_W-1:0] ha;
    logic [`PSR_HALF_W-1:0] hb;
    ha = (req.op == psr_pkg::PSR_OP_UNPKHI) ? opa[63:32] : opa[31:0];
    hb = (req.op == psr_pkg::PSR_OP_UNPKHI) ? opb[63:32] : opb[31:0];
    unique case (req.lane)
      psr_pkg::PSR_LANE_BYTE :
        for (int i = 0; i < 4; i++)
          unpk_res[i*16 +: 16] = {hb[i*8 +: 8], ha[i*8 +: 8]};
      psr_pkg::PSR_LANE_WORD :
        for (int i = 0; i < 2; i++)
          unpk_res[i*32 +: 32] = {hb[i*16 +: 16], ha[i*16 +: 16]};
      default :
        unpk_res = {hb, ha};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Destination value per access mode; mode input never alters behaviour
  always_comb
  begin
    unique case (req.src)
      psr_pkg::PSR_SRC_MEM64 :
        if (req.op == psr_pkg::PSR_OP_MOV)
          wr_val = req.wdata;
        else if (req.op == psr_pkg::PSR_OP_UNPKLO || req.op == psr_pkg::PSR_OP_UNPKHI)
          wr_val = unpk_res; // Memory operand interleaves like a register one
        else
          wr_val = alu_res;
      psr_pkg::PSR_SRC_MEM32 : wr_val = {`PSR_ZERO32, req.wdata[31:0]};
      psr_pkg::PSR_SRC_GPR32 : wr_val = {`PSR_ZERO32, req.wdata[31:0]};
      psr_pkg::PSR_SRC_ALU   :
        if (req.op == psr_pkg::PSR_OP_UNPKLO || req.op == psr_pkg::PSR_OP_UNPKHI)
          wr_val = unpk_res;
        else
          wr_val = alu_res;
      default                : wr_val = alu_res;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state for storage: packed write marks the exponent all ones,
  // FP write replaces the whole slot; packed write wins if both aim alike
  always_comb
  begin
    for (int r = 0; r < `PSR_NREGS; r++)
    begin
      slot_next[r] = slot_reg[r];
      if (fp_wr_en && fp_wr_idx == r[`PSR_IDX_W-1:0])
        slot_next[r] = fp_wr_slot;
      if (req.valid && req.src != psr_pkg::PSR_SRC_FPU && req.dst == r[`PSR_IDX_W-1:0])
      begin
        slot_next[r].mantissa = wr_val;
        slot_next[r].exponent = `PSR_EXP_ONES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read ports: stored byte k of memory is register bits 8k+7..8k
  always_comb
  begin
    rd_data_next = slot_reg[rd_idx].mantissa;
    half_next    = slot_reg[rd_idx].mantissa[31:0];
    fp_rd_next   = slot_reg[fp_rd_idx];
    done_next    = req.valid && (req.src != psr_pkg::PSR_SRC_FPU);
    for (int k = 0; k < `PSR_NBYTES; k++)
      store_next[k*8 +: 8] = slot_reg[rd_idx].mantissa[k*8 +: 8];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; exec_mode is accepted but deliberately unused
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int r = 0; r < `PSR_NREGS; r++)
        slot_reg[r] <= {`PSR_ZERO16, `PSR_ZERO64};
      rd_data_reg <= `PSR_ZERO64;
      store_reg   <= `PSR_ZERO64;
      half_reg    <= `PSR_ZERO32;
      fp_rd_reg   <= {`PSR_ZERO16, `PSR_ZERO64};
      done_reg    <= 1'b0;
    end
    else
    begin
      for (int r = 0; r < `PSR_NREGS; r++)
        slot_reg[r] <= slot_next[r];
      rd_data_reg <= rd_data_next;
      store_reg   <= store_next;
      half_reg    <= half_next;
      fp_rd_reg   <= fp_rd_next;
      done_reg    <= done_next;
    end
  end

  assign rd_data         = rd_data_reg;
  assign mem_store_bytes = store_reg;
  assign half_data       = half_reg;
  assign fp_rd_slot      = fp_rd_reg;
  assign wr_done         = done_reg;

endmodule

//--- psr_map.svh
// Constants for the packed register file: widths, counts, lane layout, fill values.
// Assumes inclusion by the package and by every design file that needs a figure.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

`define PSR_NREGS      8
`define PSR_IDX_W      3
`define PSR_DATA_W     64
`define PSR_HALF_W     32
`define PSR_EXP_W      16
`define PSR_BYTE_W     8
`define PSR_WORD_W     16
`define PSR_DWORD_W    32
`define PSR_NBYTES     8
`define PSR_NWORDS     4
`define PSR_NDWORDS    2
`define PSR_EXP_ONES   16'hFFFF
`define PSR_ZERO64     64'h0000_0000_0000_0000
`define PSR_ZERO32     32'h0000_0000
`define PSR_ZERO16     16'h0000

`endif

//--- psr_pkg.sv
// Types shared by the packed register file and its lane unit.
// Assumes psr_map.svh sits in the include path.
`include "psr_map.svh"

package psr_pkg;

  // Lane size of a packed operation
  typedef enum logic [1:0]
  {
    PSR_LANE_BYTE  = 2'b00,
    PSR_LANE_WORD  = 2'b01,
    PSR_LANE_DWORD = 2'b10,
    PSR_LANE_QWORD = 2'b11
  } psr_lane_t;

  // Operation applied lane by lane
  typedef enum logic [3:0]
  {
    PSR_OP_MOV    = 4'b0000,
    PSR_OP_ADD    = 4'b0001,
    PSR_OP_SUB    = 4'b0010,
    PSR_OP_AND    = 4'b0011,
    PSR_OP_ANDN   = 4'b0100,
    PSR_OP_OR     = 4'b0101,
    PSR_OP_XOR    = 4'b0110,
    PSR_OP_CMPEQ  = 4'b0111,
    PSR_OP_CMPGT  = 4'b1000,
    PSR_OP_ADDS   = 4'b1001,
    PSR_OP_ADDUS  = 4'b1010,
    PSR_OP_SUBS   = 4'b1011,
    PSR_OP_SUBUS  = 4'b1100,
    PSR_OP_UNPKLO = 4'b1101,
    PSR_OP_UNPKHI = 4'b1110
  } psr_op_t;

  // Where the destination is written from
  typedef enum logic [2:0]
  {
    PSR_SRC_ALU   = 3'b000,
    PSR_SRC_MEM64 = 3'b001,
    PSR_SRC_MEM32 = 3'b010,
    PSR_SRC_GPR32 = 3'b011,
    PSR_SRC_FPU   = 3'b100
  } psr_src_t;

  // One instruction-level request to the file
  typedef struct packed
  {
    logic                          valid;
    psr_src_t                      src;
    psr_op_t                       op;
    psr_lane_t                     lane;
    logic [`PSR_IDX_W-1:0]         dst;
    logic [`PSR_IDX_W-1:0]         src_a;
    logic [`PSR_IDX_W-1:0]         src_b;
    logic [`PSR_DATA_W-1:0]        wdata;
  } psr_req_t;

  // Register contents and the shared floating-point exponent field
  typedef struct packed
  {
    logic [`PSR_EXP_W-1:0]         exponent;
    logic [`PSR_DATA_W-1:0]        mantissa;
  } psr_fp_slot_t;

endpackage

//--- psr_lane_alu.sv
// Lane-parallel arithmetic and logic unit for 64-bit packed operands.
// Assumes purely combinational use by psr_register_file on one clock.
`include "psr_map.svh"
`timescale 1ns/1ps

module psr_lane_alu
(
  input  wire logic [`PSR_DATA_W-1:0] opa,
  input  wire logic [`PSR_DATA_W-1:0] opb,
  input  wire psr_pkg::psr_op_t       op,
  input  wire psr_pkg::psr_lane_t     lane,
  output logic      [`PSR_DATA_W-1:0] result
);

  ////////////////////////////////////////////////////////////////////////
  // Per-lane-size results: each byte, word or doubleword result uses its own lane's carry only
  logic [`PSR_DATA_W-1:0] byte_res;   // Byte-lane result
  logic [`PSR_DATA_W-1:0] word_res;   // Word-lane result
  logic [`PSR_DATA_W-1:0] dword_res;  // Doubleword-lane result

  // One generic lane op; width chosen at elaboration
  function automatic logic [`PSR_DWORD_W-1:0] lane_op
  (
    input logic [`PSR_DWORD_W-1:0] a,
    input logic [`PSR_DWORD_W-1:0] b,
    input psr_pkg::psr_op_t        o,
    input int                      w
  );
    logic [`PSR_DWORD_W:0]   s;
    logic [`PSR_DWORD_W:0]   d;
    logic [`PSR_DWORD_W-1:0] smax;
    logic [`PSR_DWORD_W-1:0] smin;
    logic [`PSR_DWORD_W-1:0] umax;
    logic [`PSR_DWORD_W-1:0] r;
    logic                    sa;
    logic                    sb;
    logic                    ss;
    logic                    sd;
    logic                    gt;
    umax = `PSR_ZERO32;
    for (int k = 0; k < `PSR_DWORD_W; k++)
      if (k < w) umax[k] = 1'b1;
    smax = umax >> 1;
    smin = umax & ~smax;
    s  = {1'b0, a} + {1'b0, b};
    d  = {1'b0, a} - {1'b0, b};
    sa = a[w-1];
    sb = b[w-1];
    ss = s[w-1];
    sd = d[w-1];
    // Signed greater-than within the lane width
    gt = (sa != sb) ? sb : ((a & umax) > (b & umax));
    unique case (o)
      psr_pkg::PSR_OP_ADD   : r = s[`PSR_DWORD_W-1:0];
      psr_pkg::PSR_OP_SUB   : r = d[`PSR_DWORD_W-1:0];
      psr_pkg::PSR_OP_AND   : r = a & b;
      psr_pkg::PSR_OP_ANDN  : r = ~a & b;
      psr_pkg::PSR_OP_OR    : r = a | b;
      psr_pkg::PSR_OP_XOR   : r = a ^ b;
      psr_pkg::PSR_OP_CMPEQ : r = ((a & umax) == (b & umax)) ? umax : `PSR_ZERO32;
      psr_pkg::PSR_OP_CMPGT : r = gt ? umax : `PSR_ZERO32;
      // Saturation clamps instead of wrapping; no flags are raised
      psr_pkg::PSR_OP_ADDS  : r = (sa == sb && ss != sa) ? (sa ? smin : smax) : s[`PSR_DWORD_W-1:0];
      psr_pkg::PSR_OP_SUBS  : r = (sa != sb && sd != sa) ? (sa ? smin : smax) : d[`PSR_DWORD_W-1:0];
      psr_pkg::PSR_OP_ADDUS : r = s[w] ? umax : s[`PSR_DWORD_W-1:0];
      psr_pkg::PSR_OP_SUBUS : r = d[w] ? `PSR_ZERO32 : d[`PSR_DWORD_W-1:0];
      default               : r = b;
    endcase
    return r & umax;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Lane i of width w sits at bits w*i .. w*(i+1)-1, lane 0 lowest
  genvar gi;
  generate
    for (gi = 0; gi < `PSR_NBYTES; gi++)
    begin : g_byte
      logic [`PSR_DWORD_W-1:0] rb; // Widened byte result
      assign rb = lane_op({24'h00_0000, opa[gi*8 +: 8]}, {24'h00_0000, opb[gi*8 +: 8]}, op, `PSR_BYTE_W);
      assign byte_res[gi*8 +: 8] = rb[7:0];
    end
    for (gi = 0; gi < `PSR_NWORDS; gi++)
    begin : g_word
      logic [`PSR_DWORD_W-1:0] rw; // Widened word result
      assign rw = lane_op({16'h0000, opa[gi*16 +: 16]}, {16'h0000, opb[gi*16 +: 16]}, op, `PSR_WORD_W);
      assign word_res[gi*16 +: 16] = rw[15:0];
    end
    for (gi = 0; gi < `PSR_NDWORDS; gi++)
    begin : g_dword
      assign dword_res[gi*32 +: 32] = lane_op(opa[gi*32 +: 32], opb[gi*32 +: 32], op, `PSR_DWORD_W);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Lane size selects one of the parallel results; quadword is logic only
  always_comb
  begin
    unique case (lane)
      psr_pkg::PSR_LANE_BYTE  : result = byte_res;
      psr_pkg::PSR_LANE_WORD  : result = word_res;
      psr_pkg::PSR_LANE_DWORD : result = dword_res;
      default                 : result = (op == psr_pkg::PSR_OP_AND)  ? (opa & opb)
                                       : (op == psr_pkg::PSR_OP_ANDN) ? (~opa & opb)
                                       : (op == psr_pkg::PSR_OP_OR)   ? (opa | opb)
                                       : (op == psr_pkg::PSR_OP_XOR)  ? (opa ^ opb)
                                       : opb; // Whole 64-bit block
    endcase
  end

endmodule

//--- psr_register_file_props.sv
// Concurrent checks on the ports of the packed register file.
// Assumes one clock, synchronous active-high reset, and the bind below.
`include "psr_map.svh"
`timescale 1ns/1ps

module psr_register_file_props
(
  input wire logic                  clock,
  input wire logic                  srst,
  input wire psr_pkg::psr_req_t     req,
  input wire logic [1:0]            exec_mode,
  input wire logic [`PSR_IDX_W-1:0] rd_idx,
  input wire logic                  fp_wr_en,
  input wire logic [`PSR_IDX_W-1:0] fp_wr_idx,
  input wire psr_pkg::psr_fp_slot_t fp_wr_slot,
  input wire logic [`PSR_IDX_W-1:0] fp_rd_idx,
  input wire logic [`PSR_DATA_W-1:0] rd_data,
  input wire logic [`PSR_DATA_W-1:0] mem_store_bytes,
  input wire logic [`PSR_HALF_W-1:0] half_data,
  input wire psr_pkg::psr_fp_slot_t fp_rd_slot,
  input wire logic                  wr_done
);
  // All checks share the core clock; reset masks them except the reset check
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  a_done_follows: assert property (req.valid && req.src != psr_pkg::PSR_SRC_FPU |=> wr_done)
    else $error("wr_done missing after a packed write");
  a_done_cause: assert property (wr_done |-> $past(req.valid && req.src != psr_pkg::PSR_SRC_FPU))
    else $error("wr_done without a packed write");
  a_store_little: assert property (mem_store_bytes == rd_data)
    else $error("store bytes differ from register image");
  a_half_low: assert property (half_data == rd_data[31:0])
    else $error("half_data is not the low half");
  a_reset_zero: assert property (@(posedge clock) disable iff (1'b0) srst |=> rd_data == '0 && !wr_done && fp_rd_slot == '0)
    else $error("outputs not zero after reset");
  // A whole quadword load reads back unchanged; why: format equals memory
  a_full_load: assert property ((req.valid && req.src == psr_pkg::PSR_SRC_MEM64 && req.op == psr_pkg::PSR_OP_MOV
      && req.dst == rd_idx) ##1 ($stable(rd_idx) && !req.valid && !fp_wr_en) |=> rd_data == $past(req.wdata, 2))
    else $error("quadword load not read back whole");
  a_half_load: assert property ((req.valid && req.src inside {psr_pkg::PSR_SRC_MEM32, psr_pkg::PSR_SRC_GPR32}
      && req.dst == rd_idx) ##1 ($stable(rd_idx) && !req.valid && !fp_wr_en)
      |=> rd_data[63:32] == 32'h0000_0000 && half_data == $past(req.wdata[31:0], 2))
    else $error("32-bit write did not clear the upper half");
  a_alias_exp: assert property ((req.valid && req.src != psr_pkg::PSR_SRC_FPU && req.dst == fp_rd_idx)
      ##1 ($stable(fp_rd_idx) && !req.valid && !fp_wr_en) |=> fp_rd_slot.exponent == 16'hffff)
    else $error("packed write left FP exponent unset");
  a_alias_fp: assert property ((fp_wr_en && !req.valid && fp_wr_idx == rd_idx)
      ##1 ($stable(rd_idx) && !req.valid && !fp_wr_en) |=> rd_data == $past(fp_wr_slot.mantissa, 2))
    else $error("FP write not seen in packed view");
endmodule

bind psr_register_file psr_register_file_props i_props
(
  .clock(clock), .srst(srst), .req(req), .exec_mode(exec_mode), .rd_idx(rd_idx), .fp_wr_en(fp_wr_en),
  .fp_wr_idx(fp_wr_idx), .fp_wr_slot(fp_wr_slot), .fp_rd_idx(fp_rd_idx), .rd_data(rd_data),
  .mem_store_bytes(mem_store_bytes), .half_data(half_data), .fp_rd_slot(fp_rd_slot), .wr_done(wr_done)
);

//--- psr_register_file_tb_top.sv
// Self-checking bench for the packed register file, with a shadow model.
// Assumes the checker is bound in; inputs change at the falling edge.
`include "psr_map.svh"
`timescale 1ns/1ps

module psr_register_file_tb_top;
  logic                  clock = 1'b0;        // 250 MHz core clock
  logic                  srst = 1'b1;         // Synchronous reset
  psr_pkg::psr_req_t     req = '0;            // Packed request
  logic [1:0]            exec_mode = 2'b00;   // Mode, varied at random
  logic [2:0]            rd_idx = 3'b000;     // Packed read index
  logic                  fp_wr_en = 1'b0;     // FP write strobe
  logic [2:0]            fp_wr_idx = 3'b000;  // FP write index
  psr_pkg::psr_fp_slot_t fp_wr_slot = '0;     // FP write data
  logic [2:0]            fp_rd_idx = 3'b000;  // FP read index
  logic [63:0]           rd_data;             // Observed outputs
  logic [63:0]           mem_store_bytes;
  logic [31:0]           half_data;
  psr_pkg::psr_fp_slot_t fp_rd_slot;
  logic                  wr_done;
  logic [63:0]           mdl [8];             // Shadow mantissas
  logic [15:0]           ex [8];              // Shadow exponents
  logic [31:0]           seed = 32'd99716;    // Random state
  int                    n_fail = 0;
  int                    n_compared = 0;
  int                    cycles = 0;          // Hang guard

  psr_register_file i_dut
  (
    .clock(clock), .srst(srst), .req(req), .exec_mode(exec_mode), .rd_idx(rd_idx), .fp_wr_en(fp_wr_en),
    .fp_wr_idx(fp_wr_idx), .fp_wr_slot(fp_wr_slot), .fp_rd_idx(fp_rd_idx), .rd_data(rd_data),
    .mem_store_bytes(mem_store_bytes), .half_data(half_data), .fp_rd_slot(fp_rd_slot), .wr_done(wr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is far above the some 270 cycles used
  initial
  begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linear feedback shift register source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected lane-parallel result, lane i at bits w*i upward
  function automatic logic [63:0] f_exp(logic [63:0] a, logic [63:0] b, psr_pkg::psr_op_t op,
                                        psr_pkg::psr_lane_t ln);
    int w;
    int u;
    logic [63:0] m, x, y, r, acc, h, um;
    longint sx, sy, v;
    w = 8 << ln;
    m = (w == 64) ? '1 : ((64'h1 << w) - 64'h1);
    h = 64'h1 << (w - 1);
    acc = '0;
    // Unpack interleaves low or high halves, first operand in the lower slot
    if (op inside {psr_pkg::PSR_OP_UNPKLO, psr_pkg::PSR_OP_UNPKHI})
    begin
      x = (op == psr_pkg::PSR_OP_UNPKHI) ? a >> 32 : a;
      y = (op == psr_pkg::PSR_OP_UNPKHI) ? b >> 32 : b;
      u = (w > 32) ? 32 : w;
      um = (64'h1 << u) - 64'h1;
      for (int i = 0; i < 32 / u; i++)
        acc |= (((x >> (u * i)) & um) << (2 * u * i)) | (((y >> (u * i)) & um) << (2 * u * i + u));
      return acc;
    end
    for (int i = 0; i < 64 / w; i++)
    begin
      x = (a >> (w * i)) & m;
      y = (b >> (w * i)) & m;
      // Signed lane values through an offset by the sign weight
      sx = longint'(x ^ h) - longint'(h);
      sy = longint'(y ^ h) - longint'(h);
      case (op)
        psr_pkg::PSR_OP_ADD:   r = x + y;
        psr_pkg::PSR_OP_SUB:   r = x - y;
        psr_pkg::PSR_OP_AND:   r = x & y;
        psr_pkg::PSR_OP_ANDN:  r = ~x & y;
        psr_pkg::PSR_OP_OR:    r = x | y;
        psr_pkg::PSR_OP_XOR:   r = x ^ y;
        psr_pkg::PSR_OP_CMPEQ: r = (x == y) ? m : '0;
        psr_pkg::PSR_OP_CMPGT: r = (sx > sy) ? m : '0;
        psr_pkg::PSR_OP_ADDUS: r = (x + y > m) ? m : x + y;
        psr_pkg::PSR_OP_SUBUS: r = (x < y) ? '0 : x - y;
        psr_pkg::PSR_OP_ADDS, psr_pkg::PSR_OP_SUBS:
        begin
          v = (op == psr_pkg::PSR_OP_ADDS) ? sx + sy : sx - sy;
          v = (v > longint'(h) - 1) ? longint'(h) - 1 : (v < -longint'(h)) ? -longint'(h) : v;
          r = v;
        end
        default:               r = y;
      endcase
      // Non-logic operations on the quadword lane simply pass the second operand
      if (w == 64 && !(op inside {psr_pkg::PSR_OP_AND, psr_pkg::PSR_OP_ANDN, psr_pkg::PSR_OP_OR, psr_pkg::PSR_OP_XOR}))
        r = y;
      acc |= (r & m) << (w * i);
    end
    return acc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [79:0] seen, logic [79:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, expd, seen);
    end
  endtask

  task automatic tick();
    @(posedge clock);
    @(negedge clock);
  endtask

  // Shadow update for a taken packed write
  task automatic apply(psr_pkg::psr_req_t r);
    case (r.src)
      psr_pkg::PSR_SRC_MEM64: mdl[r.dst] = (r.op == psr_pkg::PSR_OP_MOV) ? r.wdata
                                           : f_exp(mdl[r.src_a], r.wdata, r.op, r.lane);
      psr_pkg::PSR_SRC_ALU:   mdl[r.dst] = f_exp(mdl[r.src_a], mdl[r.src_b], r.op, r.lane);
      default:                mdl[r.dst] = {32'h0000_0000, r.wdata[31:0]};
    endcase
    ex[r.dst] = 16'hffff;
  endtask

  // Read one register through both views, one cycle after the index
  task automatic rd(logic [2:0] i);
    rd_idx = i;
    fp_rd_idx = i;
    tick();
    check("rd_data", rd_data, mdl[i]);
    check("store", mem_store_bytes, mdl[i]);
    check("half", half_data, mdl[i][31:0]);
    check("fp_slot", fp_rd_slot, {ex[i], mdl[i]});
    check("done_low", wr_done, 1'b0);
  endtask

  // One packed write, then read it back
  task automatic put(psr_pkg::psr_req_t r);
    exec_mode = 2'(rnd());
    req = r;
    rd_idx = r.dst;
    fp_rd_idx = r.dst;
    apply(r);
    tick();
    check("done", wr_done, 1'b1);
    req.valid = 1'b0;
    fp_wr_en = 1'b0;
    rd(r.dst);
  endtask

  function automatic psr_pkg::psr_req_t mk(psr_pkg::psr_src_t s, logic [2:0] d, logic [63:0] v);
    psr_pkg::psr_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.src = s;
    r.dst = d;
    r.wdata = v;
    return r;
  endfunction

  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    psr_pkg::psr_req_t r;
    repeat (20) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    // Everything reads zero after reset
    for (int i = 0; i < 8; i++)
    begin
      mdl[i] = '0;
      ex[i] = 16'h0000;
      rd(i);
    end
    $display("test reset done");
    // Whole quadword loads, with a corner value in the first and last
    for (int i = 0; i < 8; i++)
      put(mk(psr_pkg::PSR_SRC_MEM64, 3'(i), (i % 7 == 0) ? 64'h8000_00ff_7fff_0001 : {rnd(), rnd()}));
    $display("test load done");
    // Back-to-back random operations, each result usable next cycle
    for (int k = 0; k < 200; k++)
    begin
      r = mk(psr_pkg::PSR_SRC_ALU, 3'(rnd()), '0);
      r.op = psr_pkg::psr_op_t'(rnd() % 15);
      r.lane = psr_pkg::psr_lane_t'(rnd() % 4);
      r.src_a = 3'(rnd());
      r.src_b = 3'(rnd());
      // Every fourth operation takes its second operand from memory
      if (k % 4 == 3)
      begin
        r.src = psr_pkg::PSR_SRC_MEM64;
        r.wdata = {rnd(), rnd()};
      end
      req = r;
      apply(r);
      tick();
      check("done_b2b", wr_done, 1'b1);
    end
    req.valid = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(i);
    $display("test alu done");
    // Half-width writes from memory and from a general register
    put(mk(psr_pkg::PSR_SRC_MEM32, 3'd2, {rnd(), 32'hffff_8001}));
    put(mk(psr_pkg::PSR_SRC_GPR32, 3'd7, {rnd(), rnd()}));
    $display("test half done");
    // FP writes show in the packed view; same-index packed write wins
    fp_wr_en = 1'b1;
    fp_wr_idx = 3'd5;
    rd_idx = 3'd5;
    fp_rd_idx = 3'd5;
    fp_wr_slot = {16'h4003, rnd(), rnd()};
    mdl[5] = fp_wr_slot.mantissa;
    ex[5] = fp_wr_slot.exponent;
    tick();
    fp_wr_en = 1'b0;
    rd(3'd5);
    fp_wr_en = 1'b1;
    fp_wr_idx = 3'd6;
    put(mk(psr_pkg::PSR_SRC_MEM64, 3'd6, {rnd(), rnd()}));
    $display("test alias done");
    // Reset in mid-run clears both views of every register
    srst = 1'b1;
    tick();
    tick();
    srst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      mdl[i] = '0;
      ex[i] = 16'h0000;
      rd(3'(i));
    end
    $display("test midreset done");
    summarize();
  end
endmodule
